// ### verilog/biquad_detector_map.vh
// register offsets, field positions and reset values of the filter and detector sequencer
`ifndef BIQUAD_DETECTOR_MAP_VH
`define BIQUAD_DETECTOR_MAP_VH
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_DET1 8'h08
`define OFS_DET2 8'h0C
`define OFS_RCOEF 8'h10
`define OFS_FFCOEF 8'h14
`define OFS_FILT 8'h18
`define CTRL_RESET 2'h3
`define CTRL_DET_EN 0
`define CTRL_FILT_EN 1
`define CYCLE_LAST 5'h1F
`define CYCLE_LOAD 5'h00
`define SEL_BIT 31
`define SCALE_MSB 30
`define SCALE_LSB 27
`define BYPASS_BIT 27
`define BCOEF_MSB 26
`define BCOEF_LSB 14
`define BCOEF_SHIFT 12
`define KSCALE_MSB 9
`define KSCALE_LSB 7
`define JSCALE_MSB 6
`define JSCALE_LSB 4
`define LEVEL_MSB 31
`define LEVEL_LSB 16
`define FILT_IN_MSB 23
`define FILT_IN_LSB 8
`define RANGE_MASK 16'hFFF0
`endif

// ### verilog/biquad_detector_programming.v
// serial programming sequencer, filter data path and level detectors with an apb register view
`include "biquad_detector_map.vh"
module biquad_detector_programming (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // device pins
  input wire sync_n,
  input wire delay_select,
  input wire recursive_coefficient_stream,
  input wire feedforward_coefficient_stream,
  input wire integrator_scale_stream,
  input wire first_comparison_stream,
  input wire second_comparison_stream,
  input wire filter_data_input,
  input wire first_level_sense_input,
  input wire second_level_sense_input,
  input wire external_delay_input,
  output reg filter_data_output,
  output reg second_level_result_output
);
  localparam NS = 9;
  localparam NP = NS + 2;
  localparam S_RC = 0;
  localparam S_NR = 1;
  localparam S_IC = 2;
  localparam S_LV1 = 3;
  localparam S_LV2 = 4;
  localparam S_FI = 5;
  localparam S_D1 = 6;
  localparam S_D2 = 7;
  localparam S_XD = 8;

  // one integrator update with rectifier, range limit and leak
  function [15:0] integ_step;
    input [15:0] acc;
    input [15:0] det;
    input [15:0] comp;
    input [2:0] k;
    reg [15:0] r;
    reg [15:0] s;
    reg [3:0] sh;
    reg signed [15:0] acc_s;
    reg signed [15:0] sum_s;
    reg signed [15:0] leak_s;
    reg signed [15:0] gain_s;
    begin
      r = det[15] ? ~det : det;
      r = r & `RANGE_MASK;
      s = r + comp;
      sh = {1'b0, k} + 4'h1;
      acc_s = acc;
      sum_s = s;
      // shifts stay in a signed context so negative values keep their sign
      leak_s = acc_s >>> sh;
      gain_s = sum_s >>> sh;
      integ_step = acc - leak_s + gain_s;
    end
  endfunction

  // two-stage synchronisers for every pin input
  wire [NP-1:0] pin_in;
  reg [NP-1:0] meta_r;
  reg [NP-1:0] pin_r;
  assign pin_in = {delay_select, sync_n, external_delay_input, second_level_sense_input,
                   first_level_sense_input, filter_data_input, second_comparison_stream,
                   first_comparison_stream, integrator_scale_stream,
                   feedforward_coefficient_stream, recursive_coefficient_stream};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= {NP{1'b1}};
      pin_r <= {NP{1'b1}};
    end else begin
      meta_r <= pin_in;
      pin_r <= meta_r;
    end
  end
  wire sync_low = ~pin_r[NS];
  wire dly_int = pin_r[NS+1];

  // pulse counter, zero is clock pulse one of the cycle
  reg [4:0] pulse_r;
  wire [4:0] pulse_nxt = sync_low ? 5'h00 : pulse_r + 5'h01;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pulse_r <= `CYCLE_LAST;
    else
      pulse_r <= pulse_nxt;
  end
  wire cyc_end = (pulse_nxt == `CYCLE_LAST);
  reg load_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      load_r <= 1'b0;
    else
      load_r <= cyc_end;
  end

  // per-stream shift in, lsb first, whole word latched at pulse 32
  reg [31:0] word_r [0:NS-1];
  genvar g;
  generate
    for (g = 0; g < NS; g = g + 1) begin : stream
      reg [31:0] sh_r;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sh_r <= 32'h00000000;
          word_r[g] <= 32'h00000000;
        end else begin
          sh_r <= {pin_r[g], sh_r[31:1]};
          if (cyc_end)
            word_r[g] <= {pin_r[g], sh_r[31:1]};
        end
      end
    end
  endgenerate

  // fields of the latched words
  wire in_sel = word_r[S_RC][`SEL_BIT];
  wire [3:0] scale_m = word_r[S_RC][`SCALE_MSB:`SCALE_LSB];
  wire bypass_n = word_r[S_NR][`BYPASS_BIT];
  wire [12:0] bcoef = word_r[S_NR][`BCOEF_MSB:`BCOEF_LSB];
  wire [2:0] kscale = word_r[S_IC][`KSCALE_MSB:`KSCALE_LSB];
  wire [2:0] jscale = word_r[S_IC][`JSCALE_MSB:`JSCALE_LSB];
  wire [15:0] level1 = word_r[S_LV1][`LEVEL_MSB:`LEVEL_LSB];
  wire [15:0] level2 = word_r[S_LV2][`LEVEL_MSB:`LEVEL_LSB];
  wire [15:0] det1_in = word_r[S_D1][`LEVEL_MSB:`LEVEL_LSB];
  wire [15:0] det2_in = word_r[S_D2][`LEVEL_MSB:`LEVEL_LSB];
  wire [15:0] ext_in = word_r[S_FI][`FILT_IN_MSB:`FILT_IN_LSB];
  wire [15:0] xdly_in = word_r[S_XD][`FILT_IN_MSB:`FILT_IN_LSB];

  // control register
  reg [1:0] ctrl_r;
  wire det_en = ctrl_r[`CTRL_DET_EN];
  wire filt_en = ctrl_r[`CTRL_FILT_EN];

  // filter data path: source select, recirculation, secondary multiplier
  reg [15:0] filt_r;
  wire [15:0] recirc = dly_int ? filt_r : xdly_in;
  wire [15:0] src = in_sel ? ext_in : recirc;
  wire signed [28:0] prod = $signed(src) * $signed(bcoef);
  wire [15:0] filt_nxt = bypass_n ? prod[`BCOEF_SHIFT+15:`BCOEF_SHIFT] : src;

  // detector integrators
  reg [15:0] acc1_r;
  reg [15:0] acc2_r;
  reg [15:0] det_sh_r;
  reg [15:0] filt_sh_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc1_r <= 16'h0000;
      acc2_r <= 16'h0000;
      filt_r <= 16'h0000;
      det_sh_r <= 16'h0000;
      filt_sh_r <= 16'h0000;
    end else if (load_r) begin
      if (det_en) begin
        acc1_r <= integ_step(acc1_r, det1_in, level1, jscale);
        acc2_r <= integ_step(acc2_r, det2_in, level2, kscale);
      end
      if (filt_en)
        filt_r <= filt_nxt;
      det_sh_r <= acc2_r;
      filt_sh_r <= filt_r;
    end else begin
      det_sh_r <= {1'b0, det_sh_r[15:1]};
      filt_sh_r <= {1'b0, filt_sh_r[15:1]};
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_level_result_output <= 1'b0;
      filter_data_output <= 1'b0;
    end else begin
      second_level_result_output <= det_sh_r[0];
      filter_data_output <= filt_sh_r[0];
    end
  end

  // apb slave, one wait state
  wire access = psel & penable;
  wire done = access & pready;
  reg [31:0] rd_val;
  reg rd_err;
  always @* begin
    rd_val = 32'h00000000;
    rd_err = 1'b0;
    if (paddr == `OFS_CTRL)
      rd_val = {30'h00000000, ctrl_r};
    else if (paddr == `OFS_STATUS)
      rd_val = {17'h00000, acc2_r[15], acc1_r[15], dly_int, bypass_n, in_sel, kscale, jscale, scale_m};
    else if (paddr == `OFS_DET1)
      rd_val = {16'h0000, acc1_r};
    else if (paddr == `OFS_DET2)
      rd_val = {16'h0000, acc2_r};
    else if (paddr == `OFS_RCOEF)
      rd_val = word_r[S_RC];
    else if (paddr == `OFS_FFCOEF)
      rd_val = word_r[S_NR];
    else if (paddr == `OFS_FILT)
      rd_val = {16'h0000, filt_r};
    else
      rd_err = 1'b1;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      ctrl_r <= `CTRL_RESET;
    end else begin
      pready <= access & ~pready;
      if (access & ~pready) begin
        prdata <= pwrite ? 32'h00000000 : rd_val;
        pslverr <= rd_err;
      end else begin
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
      end
      if (done & pwrite & (paddr == `OFS_CTRL))
        ctrl_r <= pwdata[1:0];
    end
  end
endmodule

// ### verif/bq_checker.sv
// apb answer timing checks of the sequencer's register port
module bq_checker (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_ready_answer: assert property (psel && penable && !pready |=> pready)
    else $error("no answer");
  a_ready_idle: assert property (!(psel && penable) |=> !pready)
    else $error("stray pready");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("lone pslverr");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h00000000)
    else $error("prdata not zero");
  a_err_zero: assert property (pslverr |-> prdata == 32'h00000000)
    else $error("error read data");
  a_err_unmapped: assert property (psel && penable && !pready && paddr > 8'h18 |=> pslverr)
    else $error("unmapped accepted");
  a_err_mapped: assert property (psel && penable && !pready && paddr <= 8'h18 && paddr[1:0] == 2'h0
    |=> !pslverr)
    else $error("mapped refused");
endmodule

// ### verif/coef_memory.sv
// counter-addressed coefficient memory, one word per stream
module coef_memory (
  // clock and words
  input wire logic pclk,
  input wire logic [31:0] word_q [9],
  // streams
  output logic sync_n,
  output logic [8:0] bit_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt_r = 5'h00;
  always @(posedge pclk) cnt_r <= cnt_r + 5'h01;
  always_comb begin
    sync_n = cnt_r != 5'h00;
    for (int i = 0; i < 9; i++) begin
      bit_q[i] = word_q[i][cnt_r];
    end
  end
endmodule

// ### verif/biquad_detector_programming_bench.sv
// self-checking bench of the filter and detector sequencer
module biquad_detector_programming_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic delay_select = 1'b1;
  logic [31:0] wd [9] = '{default: 32'h00000000};
  wire [31:0] prdata;
  wire pready, pslverr, sync_n, fout, rout;
  wire [8:0] sb;
  int bad_count = 0;
  int n_compared = 0;
  always #25 pclk = ~pclk;
  coef_memory mem (.pclk(pclk), .word_q(wd), .sync_n(sync_n), .bit_q(sb));
  biquad_detector_programming DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_n(sync_n), .delay_select(delay_select), .recursive_coefficient_stream(sb[0]),
    .feedforward_coefficient_stream(sb[1]), .integrator_scale_stream(sb[2]), .first_comparison_stream(sb[3]),
    .second_comparison_stream(sb[4]), .filter_data_input(sb[5]), .first_level_sense_input(sb[6]),
    .second_level_sense_input(sb[7]), .external_delay_input(sb[8]), .filter_data_output(fout),
    .second_level_result_output(rout));
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  // coefficient encoders of the memory side
  function automatic logic [13:0] a_code(input logic [12:0] mag, input logic neg);
    logic [13:0] c;
    if (neg) begin
      c = {1'b1, ~mag} + 14'h0001;
    end else begin
      c = {1'b0, ~mag[12], mag[11:0]};
    end
    return c;
  endfunction
  function automatic logic [12:0] b_code(input logic [11:0] mag, input logic neg);
    logic [12:0] c;
    if (neg) begin
      c = {1'b1, ~mag + 12'h001};
    end else begin
      c = {1'b0, mag};
    end
    return c;
  endfunction
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h00000000, q, e);
    chk($sformatf("reg %h", a), x, q & m);
  endtask
  task fr(input int n);
    repeat (32 * n) @(posedge pclk);
  endtask
  task t_reset;
    logic [31:0] q;
    logic e;
    rchk(8'h00, 32'h00000003, 32'hFFFFFFFF);
    apb(1'b1, 8'h40, 32'h0000FFFF, q, e);
    chk("unmapped err", 32'h00000001, {31'h0, e});
    $display("test reset done");
  endtask
  task t_filter;
    wd[0] <= 32'hD0000000 | {18'h00000, a_code(13'h0123, 1'b0)};
    wd[2] <= 32'h00000130;
    wd[5] <= 32'h00ABCD00;
    fr(3);
    rchk(8'h04, 32'h0000153A, 32'h00001FFF);
    rchk(8'h10, 32'hD0001123, 32'hFFFFFFFF);
    rchk(8'h18, 32'h0000ABCD, 32'h0000FFFF);
    wd[0] <= 32'h50000000;
    wd[5] <= 32'h00111100;
    fr(3);
    rchk(8'h18, 32'h0000ABCD, 32'h0000FFFF);
    delay_select <= 1'b0;
    wd[8] <= 32'h00135700;
    fr(3);
    rchk(8'h18, 32'h00001357, 32'h0000FFFF);
    wd[0] <= 32'hD0000000;
    wd[1] <= {4'h0, 1'b1, b_code(12'h800, 1'b0), 14'h0000};
    wd[5] <= 32'h00100000;
    fr(3);
    rchk(8'h18, 32'h00000800, 32'h0000FFFF);
    wd[0] <= 32'hD0000000 | {18'h00000, a_code(13'h0123, 1'b1)};
    wd[1] <= {4'h0, 1'b1, b_code(12'h800, 1'b1), 14'h0000};
    fr(3);
    rchk(8'h10, 32'hD0003EDD, 32'hFFFFFFFF);
    rchk(8'h14, 32'h0E000000, 32'hFFFFFFFF);
    rchk(8'h18, 32'h0000F800, 32'h0000FFFF);
    $display("test filter done");
  endtask
  task t_detect;
    logic [31:0] w;
    logic [31:0] v;
    logic hit;
    logic fhit;
    wd[7] <= 32'h000F0000;
    fr(20);
    rchk(8'h0C, 32'h00000000, 32'h0000FFFF);
    wd[6] <= 32'h10000000;
    wd[3] <= 32'hF8000000;
    wd[7] <= 32'h12300000;
    fr(150);
    rchk(8'h08, 32'h00000800, 32'h0000FFFF);
    rchk(8'h0C, 32'h00001230, 32'h0000FFFF);
    for (int i = 0; i < 32; i++) begin
      @(posedge pclk);
      w[i] = rout;
      v[i] = fout;
    end
    hit = 1'b0;
    fhit = 1'b0;
    for (int r = 0; r < 32; r++) begin
      if (32'({w, w} >> r) === 32'h00001230) begin
        hit = 1'b1;
      end
      if (32'({v, v} >> r) === 32'h0000F800) begin
        fhit = 1'b1;
      end
    end
    chk("result stream", 32'h00000001, {31'h0, hit});
    chk("filter stream", 32'h00000001, {31'h0, fhit});
    $display("test detect done");
  endtask
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_filter();
    t_detect();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    report_and_stop();
  end
endmodule
bind biquad_detector_programming bq_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
